// ==== hdl/ivp_arbiter.sv ====
// ranks pending candidates by level, then by natural vector order
`timescale 1ns/1ps
module ivp_arbiter (
  ivp_core_if.arb_mp ar
);
  import ivp_pkg::*;

  always_comb begin
    ar.win_valid = 1'b0;
    ar.win_vec   = 7'h00;
    ar.win_lvl   = 4'h0;
    // walk from the top down so an equal level at a lower vector replaces the holder
    for (int i = 125; i >= 0; i--) begin
      if (ar.cand_req[i] && (!ar.win_valid || ar.cand_lvl[i] >= ar.win_lvl)) begin
        ar.win_valid = 1'b1;
        ar.win_vec   = 7'(i);
        ar.win_lvl   = ar.cand_lvl[i];
      end
    end
  end
endmodule // ivp_arbiter

// ==== hdl/ivp_core_if.sv ====
// internal carrier between the prioritizer top, its arbiter and its vector table
`timescale 1ns/1ps
interface ivp_core_if;
  import ivp_pkg::*;
  logic [125:0]      cand_req;
  logic [125:0][3:0] cand_lvl;
  logic              win_valid;
  ivp_vec_t          win_vec;
  ivp_lvl_t          win_lvl;
  logic              tbl_we;
  ivp_tidx_t         tbl_waddr;
  ivp_addr_t         tbl_wdata;
  ivp_tidx_t         tbl_raddr;
  ivp_addr_t         tbl_rdata;
  ivp_tidx_t         tbl_baddr;
  ivp_addr_t         tbl_bdata;
  modport top_mp (output cand_req, cand_lvl, tbl_we, tbl_waddr, tbl_wdata, tbl_raddr, tbl_baddr,
                  input win_valid, win_vec, win_lvl, tbl_rdata, tbl_bdata);
  modport arb_mp (input cand_req, cand_lvl, output win_valid, win_vec, win_lvl);
  modport tbl_mp (input tbl_we, tbl_waddr, tbl_wdata, tbl_raddr, tbl_baddr, output tbl_rdata, tbl_bdata);
endinterface

// ==== hdl/ivp_map.svh ====
// register offsets, field positions, reset values and table geometry of the vector prioritizer
`ifndef IVP_MAP_SVH
`define IVP_MAP_SVH

`define IVP_NUM_TRAP      8
`define IVP_NUM_SRC       118
`define IVP_NUM_VEC       126
`define IVP_FIRST_SRC_VEC 8
`define IVP_NUM_LEVELS    7

`define IVP_OFF_CTRL      12'h000
`define IVP_OFF_STATUS    12'h004
`define IVP_OFF_FLAG0     12'h010
`define IVP_OFF_EN0       12'h020
`define IVP_OFF_PRIO0     12'h040
`define IVP_NUM_BIT_WORDS 4
`define IVP_NUM_PRIO_WORDS 15
`define IVP_OFF_TABLE     12'h400

`define IVP_ALT_SEL_BIT   15
`define IVP_STAT_VEC_LSB  0
`define IVP_STAT_LVL_LSB  8
`define IVP_STAT_REQ_BIT  16
`define IVP_PRIO_MASK     32'h7777_7777

`define IVP_PRI_BASE      24'h000004
`define IVP_ALT_BASE      24'h000104
`define IVP_RESET_PC      24'h000000
`define IVP_CTRL_RST      32'h0000_0000

`endif

// ==== hdl/ivp_pkg.sv ====
// types shared by the vector prioritizer modules
package ivp_pkg;
  typedef logic [6:0]  ivp_vec_t;
  typedef logic [3:0]  ivp_lvl_t;
  typedef logic [23:0] ivp_addr_t;
  typedef logic [7:0]  ivp_tidx_t;
  typedef enum logic [1:0] {
    IVP_BUS_IDLE = 2'b00,
    IVP_BUS_ACK  = 2'b01
  } ivp_bus_e;
endpackage

// ==== hdl/ivp_top.sv ====
// interrupt vector prioritizer: flags, enables, levels, table select and request to the core
//
// Functional notes
// - all sources merge into one core request
// - each source gets one of seven levels
// - primary table starts at word 000004h
// - 126 entries: 8 traps, 118 sources
// - entry holds 24-bit handler start address
// - lower vector wins at equal level
// - equal levels resolved by fixed vector order
// - every source owns its own vector entry
// - up to 118 maskable, eight trap sources
// - select bit 15 switches to alternate table
// - alternate table mirrors primary table layout
// - first source vector 8, at 0x14/0x114
// - reset starts execution at address zero
// - fixed entry and return latencies
// - hardware sets flag, software only clears
// - per-source enable gates each flag
// - bits laid out in vector order
// - latch vector number and new level
`timescale 1ns/1ps
`include "ivp_map.svh"
module ivp_top (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [11:0]      avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  input  wire logic [117:0]     src_req_i,
  input  wire logic [7:0]       trap_req_i,
  input  wire ivp_pkg::ivp_lvl_t cpu_level_i,
  output logic                  irq_o,
  output ivp_pkg::ivp_vec_t     irq_vector_o,
  output ivp_pkg::ivp_lvl_t     irq_level_o,
  output ivp_pkg::ivp_addr_t    irq_entry_addr_o,
  output ivp_pkg::ivp_addr_t    irq_handler_o,
  output logic                  boot_start_o,
  output ivp_pkg::ivp_addr_t    boot_pc_o
);
  import ivp_pkg::*;

  ivp_core_if cif ();

  ivp_arbiter u_arb (
    .ar (cif.arb_mp)
  );

  ivp_vec_table u_tbl (
    .core_clk_i (core_clk_i),
    .tb         (cif.tbl_mp)
  );

  // byte-lane merge, shared by every writable register
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // word address of a vector's entry in the selected table
  function automatic ivp_addr_t entry_addr(input logic alt, input ivp_vec_t v);
    ivp_addr_t base;
    base = alt ? `IVP_ALT_BASE : `IVP_PRI_BASE;
    return base + {16'h0000, v, 1'b0};
  endfunction

  // register window decode, shared by the read and the write side
  function automatic logic in_flags(input logic [11:0] adr);
    return (adr >= `IVP_OFF_FLAG0) && (adr < `IVP_OFF_EN0);
  endfunction

  function automatic logic in_enables(input logic [11:0] adr);
    return (adr >= `IVP_OFF_EN0) && (adr < `IVP_OFF_EN0 + 12'h010);
  endfunction

  function automatic logic in_levels(input logic [11:0] adr);
    return (adr >= `IVP_OFF_PRIO0) && (adr < `IVP_OFF_PRIO0 + 12'h03c);
  endfunction

  // three-bit user level of source s, eight sources to a word
  function automatic logic [2:0] src_level(input logic [14:0][31:0] p, input int s);
    return p[s/8][4*(s%8) +: 3];
  endfunction

  localparam logic [127:0] SRC_MASK = (128'h1 << `IVP_NUM_SRC) - 128'h1;

  // bus handshake state
  ivp_bus_e         bus_q;
  ivp_bus_e         bus_d;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  // control and source state
  logic [31:0]      ctrl_q;
  logic [31:0]      ctrl_d;
  logic [127:0]     flag_q;
  logic [127:0]     flag_d;
  logic [127:0]     en_q;
  logic [127:0]     en_d;
  logic [14:0][31:0] prio_q;
  logic [14:0][31:0] prio_d;
  // pending vector status and request pipeline
  ivp_vec_t         svec_q;
  ivp_vec_t         svec_d;
  ivp_lvl_t         slvl_q;
  ivp_lvl_t         slvl_d;
  logic             sreq_q;
  logic             sreq_d;
  logic             salt_q;
  logic             salt_d;
  logic             irq_q;
  logic             irq_d;
  ivp_vec_t         ovec_q;
  ivp_vec_t         ovec_d;
  ivp_lvl_t         olvl_q;
  ivp_lvl_t         olvl_d;
  ivp_addr_t        oent_q;
  ivp_addr_t        oent_d;
  logic             boot_q;

  logic             acc;
  logic             wr_go;
  logic [11:0]      a;
  logic [1:0]       wi;
  logic [3:0]       pi;
  logic [127:0]     clr;
  logic             alt_sel;

  assign acc     = avs_read_i | avs_write_i;
  assign wr_go   = avs_write_i && (bus_q == IVP_BUS_ACK);
  assign a       = avs_address_i;
  assign wi      = a[3:2];
  assign pi      = 4'(a[5:2]);
  assign alt_sel = ctrl_q[`IVP_ALT_SEL_BIT];

  // one wait cycle on every access, so the answer always lands on the second edge
  always_comb begin
    bus_d = IVP_BUS_IDLE;
    if (acc && bus_q == IVP_BUS_IDLE) begin
      bus_d = IVP_BUS_ACK;
    end
  end
  assign avs_waitrequest_o = acc && (bus_q == IVP_BUS_IDLE);

  // read decode; reserved and unmapped words read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (a == `IVP_OFF_CTRL) begin
      rdata_d = ctrl_q;
    end else if (a == `IVP_OFF_STATUS) begin
      rdata_d[`IVP_STAT_VEC_LSB +: 7] = svec_q;
      rdata_d[`IVP_STAT_LVL_LSB +: 4] = slvl_q;
      rdata_d[`IVP_STAT_REQ_BIT]      = sreq_q;
    end else if (in_flags(a)) begin
      rdata_d = flag_q[32*wi +: 32];
    end else if (in_enables(a)) begin
      rdata_d = en_q[32*wi +: 32];
    end else if (in_levels(a)) begin
      rdata_d = prio_q[pi];
    end else if (a >= `IVP_OFF_TABLE) begin
      rdata_d = {8'h00, cif.tbl_bdata};
    end
  end
  // table read port follows the address; its data is ready on the acknowledging edge
  assign cif.tbl_baddr = a[9:2];

  // register writes and source flags
  always_comb begin
    ctrl_d = ctrl_q;
    en_d   = en_q;
    prio_d = prio_q;
    clr    = 128'h0;
    if (wr_go) begin
      if (a == `IVP_OFF_CTRL) begin
        ctrl_d = merge_be(ctrl_q, avs_writedata_i, avs_byteenable_i) & (32'h1 << `IVP_ALT_SEL_BIT);
      end else if (in_flags(a)) begin
        // write one to clear; a zero leaves the flag alone
        clr[32*wi +: 32] = merge_be(32'h0, avs_writedata_i, avs_byteenable_i);
      end else if (in_enables(a)) begin
        en_d[32*wi +: 32] = merge_be(en_q[32*wi +: 32], avs_writedata_i, avs_byteenable_i);
      end else if (in_levels(a)) begin
        prio_d[pi] = merge_be(prio_q[pi], avs_writedata_i, avs_byteenable_i) & `IVP_PRIO_MASK;
      end
    end
    en_d   = en_d & SRC_MASK;
    // a request arriving with the clear still sets the flag
    flag_d = ((flag_q & ~clr) | {10'h000, src_req_i}) & SRC_MASK;
  end

  // table writes through the bus, index bit 7 selects the alternate half
  assign cif.tbl_we    = wr_go && (a >= `IVP_OFF_TABLE);
  assign cif.tbl_waddr = a[9:2];
  assign cif.tbl_wdata = avs_writedata_i[23:0];

  // candidates: traps at vectors 0..7 above every user level, sources from vector 8
  always_comb begin
    cif.cand_req = '0;
    cif.cand_lvl = '0;
    for (int v = 0; v < `IVP_NUM_TRAP; v++) begin
      cif.cand_req[v] = trap_req_i[v];
      cif.cand_lvl[v] = 4'(15 - v);
    end
    for (int s = 0; s < `IVP_NUM_SRC; s++) begin
      // level zero keeps a source out of arbitration
      cif.cand_req[s + `IVP_FIRST_SRC_VEC] = flag_q[s] & en_q[s] & (src_level(prio_q, s) != 3'h0);
      cif.cand_lvl[s + `IVP_FIRST_SRC_VEC] = {1'b0, src_level(prio_q, s)};
    end
  end

  // stage one latches the winner, stage two presents it with its handler
  always_comb begin
    svec_d = svec_q;
    slvl_d = slvl_q;
    sreq_d = cif.win_valid && (cif.win_lvl > cpu_level_i);
    salt_d = alt_sel;
    if (cif.win_valid) begin
      svec_d = cif.win_vec;
      slvl_d = cif.win_lvl;
    end
    irq_d  = sreq_q;
    ovec_d = svec_q;
    olvl_d = slvl_q;
    oent_d = entry_addr(salt_q, svec_q);
  end
  assign cif.tbl_raddr = {salt_q, svec_q};

  // bus handshake and read data
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_q   <= IVP_BUS_IDLE;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_q   <= bus_d;
      rdata_q <= rdata_d;
    end
  end

  // software-visible control, flags, enables and levels
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q  <= `IVP_CTRL_RST;
      flag_q  <= 128'h0;
      en_q    <= 128'h0;
      prio_q  <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      flag_q  <= flag_d;
      en_q    <= en_d;
      prio_q  <= prio_d;
    end
  end

  // pending status, request pipeline and boot pulse
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      svec_q  <= 7'h00;
      slvl_q  <= 4'h0;
      sreq_q  <= 1'b0;
      salt_q  <= 1'b0;
      irq_q   <= 1'b0;
      ovec_q  <= 7'h00;
      olvl_q  <= 4'h0;
      oent_q  <= 24'h000000;
      boot_q  <= 1'b1;
    end else begin
      svec_q  <= svec_d;
      slvl_q  <= slvl_d;
      sreq_q  <= sreq_d;
      salt_q  <= salt_d;
      irq_q   <= irq_d;
      ovec_q  <= ovec_d;
      olvl_q  <= olvl_d;
      oent_q  <= oent_d;
      boot_q  <= 1'b0;
    end
  end

  // table data is registered inside the table, so it lines up with stage two
  assign avs_readdata_o   = (a >= `IVP_OFF_TABLE) ? {8'h00, cif.tbl_bdata} : rdata_q;
  assign irq_o            = irq_q;
  assign irq_vector_o     = ovec_q;
  assign irq_level_o      = olvl_q;
  assign irq_entry_addr_o = oent_q;
  assign irq_handler_o    = cif.tbl_rdata;
  // reset never goes through the arbiter: the core simply loads address zero
  assign boot_start_o     = boot_q;
  assign boot_pc_o        = `IVP_RESET_PC;
endmodule // ivp_top

// ==== hdl/ivp_vec_table.sv ====
// primary and alternate vector tables, one 24-bit handler address per entry
`timescale 1ns/1ps
module ivp_vec_table (
  input  wire logic  core_clk_i,
  ivp_core_if.tbl_mp tb
);
  import ivp_pkg::*;

  // index bit 7 picks the alternate half, so both halves share one layout
  ivp_addr_t mem [0:255];
  ivp_addr_t rd_d;
  ivp_addr_t rd_q;
  ivp_addr_t bd_d;
  ivp_addr_t bd_q;

  always_comb begin
    rd_d = mem[tb.tbl_raddr];
    bd_d = mem[tb.tbl_baddr];
  end

  // no reset on the array: contents are software's, like program memory
  always_ff @(posedge core_clk_i) begin
    if (tb.tbl_we) begin
      mem[tb.tbl_waddr] <= tb.tbl_wdata;
    end
    rd_q <= rd_d;
    bd_q <= bd_d;
  end

  assign tb.tbl_rdata = rd_q;
  assign tb.tbl_bdata = bd_q;
endmodule // ivp_vec_table

// ==== tb/ivp_core_model.sv ====
// behavioural core that services the single interrupt request
`timescale 1ns/1ps
module ivp_core_model (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              irq_i,
  input  wire ivp_pkg::ivp_lvl_t irq_level_i,
  input  wire logic              svc_en_i,
  input  wire logic [3:0]        delay_i,
  output ivp_pkg::ivp_lvl_t      cpu_level_o
);
  import ivp_pkg::*;
  logic [3:0] wait_q;
  // entering a handler lifts the core level, which withdraws the request
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_level_o <= '0;
      wait_q      <= '0;
    end else if (!svc_en_i || !irq_i) begin
      wait_q <= '0;
      if (!svc_en_i) cpu_level_o <= '0;
    end else if (wait_q == delay_i) begin
      cpu_level_o <= irq_level_i;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // ivp_core_model

// ==== tb/ivp_top_checker.sv ====
// assertion checker for the vector prioritizer top ports
`timescale 1ns/1ps
module ivp_top_checker (
  input wire logic               core_clk_i,
  input wire logic               rst_n_i,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic               avs_waitrequest_o,
  input wire logic [7:0]         trap_req_i,
  input wire ivp_pkg::ivp_lvl_t  cpu_level_i,
  input wire logic               irq_o,
  input wire ivp_pkg::ivp_vec_t  irq_vector_o,
  input wire ivp_pkg::ivp_lvl_t  irq_level_o,
  input wire ivp_pkg::ivp_addr_t irq_entry_addr_o,
  input wire logic               boot_start_o,
  input wire ivp_pkg::ivp_addr_t boot_pc_o
);
  import ivp_pkg::*;
  ivp_addr_t voff;
  assign voff = {16'h0, irq_vector_o, 1'b0};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_boot_pc: assert property (boot_pc_o == 24'h000000) else $error("boot pc not zero");
  chk_boot_drop: assert property ($rose(rst_n_i) |=> !boot_start_o) else $error("boot pulse too long");
  chk_wait_first: assert property (
    (avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait cycle");
  chk_wait_one: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait too long");
  chk_irq_above: assert property (irq_o |-> irq_level_o > $past(cpu_level_i, 2))
    else $error("request at or below core level");
  chk_trap_wins: assert property (
    trap_req_i[0] && cpu_level_i != 4'hf ##1 trap_req_i[0] && cpu_level_i != 4'hf
    |=> irq_o && irq_vector_o == 7'd0) else $error("trap zero not served in time");
  chk_entry_addr: assert property (
    irq_o |-> irq_entry_addr_o == 24'h000004 + voff || irq_entry_addr_o == 24'h000104 + voff)
    else $error("bad entry address");
  chk_trap_level: assert property (
    irq_o && irq_vector_o < 7'd8 |-> irq_level_o == 4'hf - irq_vector_o[3:0])
    else $error("bad trap level");
  chk_user_level: assert property (
    irq_o && irq_vector_o >= 7'd8 |-> irq_level_o inside {[4'h1:4'h7]})
    else $error("bad user level");
  chk_vec_range: assert property (irq_o |-> irq_vector_o <= 7'd125) else $error("vector out of table");
  cover property (irq_o && irq_vector_o >= 7'd8);
  cover property (irq_o && irq_vector_o == 7'd0);
  cover property (irq_o && irq_entry_addr_o >= 24'h000104);
  cover property ($fell(irq_o));
endmodule // ivp_top_checker

bind ivp_top ivp_top_checker chk_u (.core_clk_i, .rst_n_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .trap_req_i, .cpu_level_i, .irq_o, .irq_vector_o, .irq_level_o, .irq_entry_addr_o, .boot_start_o, .boot_pc_o);

// ==== tb/tb_ivp_top.sv ====
// self-checking bench for the interrupt vector prioritizer
`timescale 1ns/1ps
module tb_ivp_top;
  import ivp_pkg::*;
  logic         core_clk, rst_n, rd, wr, irq, boot, wt, svc;
  logic [11:0]  addr;
  logic [31:0]  wdata, rdata;
  logic [3:0]   be, dly;
  logic [117:0] src;
  logic [7:0]   trap;
  ivp_lvl_t     cpu, lvl;
  ivp_vec_t     vec;
  ivp_addr_t    ent, hnd, bpc;
  int           miscompares, n_compared;
  ivp_top dut_u (.core_clk_i(core_clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .src_req_i(src), .trap_req_i(trap), .cpu_level_i(cpu), .irq_o(irq),
    .irq_vector_o(vec), .irq_level_o(lvl), .irq_entry_addr_o(ent), .irq_handler_o(hnd),
    .boot_start_o(boot), .boot_pc_o(bpc));
  ivp_core_model core_u (.core_clk_i(core_clk), .rst_n_i(rst_n), .irq_i(irq), .irq_level_i(lvl),
    .svc_en_i(svc), .delay_i(dly), .cpu_level_o(cpu));
  // wide enough for the whole request bundle of irq, vector, level, entry and handler
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    // no cycle limit of its own: the watchdog ends a wait that never comes
    do begin
      @(posedge core_clk);
    end while (wt !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // flag set at the edge after the pulse, request two edges later
  task automatic fire(input int s);
    @(posedge core_clk);
    src[s] <= 1'b1;
    @(posedge core_clk);
    src[s] <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_reset;
    chk(boot, 1'b0);
    chk(bpc, 24'h0);
    chk(irq, 1'b0);
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h0);
    rdc(12'h100, 32'h0);
  endtask
  task automatic t_table;
    for (int i = 0; i < 256; i++) wr32(12'h400 + 12'(4 * i), 32'h000200);
    wr32(12'h420, 32'h00a0b0);
    wr32(12'h620, 32'h00c0d0);
    wr32(12'h600, 32'h001020);
    rdc(12'h420, 32'h00a0b0);
  endtask
  task automatic t_src;
    wr32(12'h020, 32'h3);
    wr32(12'h040, 32'h33);
    fire(1);
    chk({irq, vec, ent}, {1'b1, 7'd9, 24'h000016});
    fire(0);
    chk({irq, vec, lvl, ent, hnd}, {1'b1, 7'd8, 4'd3, 24'h000014, 24'h00a0b0});
    rdc(12'h004, 32'h0001_0308);
    rdc(12'h010, 32'h3);
    wr32(12'h040, 32'h63);
    repeat (3) @(posedge core_clk);
    chk({vec, lvl}, {7'd9, 4'd6});
    svc <= 1'b1;
    dly <= 4'd2;
    repeat (8) @(posedge core_clk);
    chk({irq, cpu}, {1'b0, 4'd6});
    wr32(12'h010, 32'h2);
    rdc(12'h010, 32'h1);
    svc <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({irq, vec}, {1'b1, 7'd8});
    wr32(12'h020, 32'h2);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0);
    wr32(12'h010, 32'h1);
    rdc(12'h010, 32'h0);
  endtask
  task automatic t_alt;
    wr32(12'h020, 32'h1);
    wr32(12'h000, 32'h8000);
    rdc(12'h000, 32'h8000);
    fire(0);
    chk({irq, ent, hnd}, {1'b1, 24'h000114, 24'h00c0d0});
  endtask
  task automatic t_trap;
    @(posedge core_clk);
    trap[0] <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({irq, vec, lvl, ent, hnd}, {1'b1, 7'd0, 4'hf, 24'h000104, 24'h001020});
    trap[0] <= 1'b0;
    wr32(12'h010, 32'h1);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0);
  endtask
  // reset in mid-run must drop the request and clear table select and status
  task automatic t_rerun;
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    chk({boot, irq}, {1'b1, 1'b0});
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(boot, 1'b0);
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    {rst_n, rd, wr, svc, addr, wdata, src, trap, dly} = '0;
    be = 4'hf;
    repeat (4) @(posedge core_clk);
    chk(boot, 1'b1);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset;
    t_table;
    t_src;
    t_alt;
    t_trap;
    t_rerun;
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    tally_and_finish;
  end
endmodule // tb_ivp_top
